// *** bench/dac_model.sv ***
// Converter model that latches both monitor codes on each valid pulse.
// Assumes codes are signed 16-bit and valid is a one-cycle pulse.
`timescale 1ns/10ps
module dac_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic code_valid,
  input wire logic [15:0] code_a,
  input wire logic [15:0] code_b,
  output logic [15:0] dac_a,
  output logic [15:0] dac_b
);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dac_a <= 16'h0;
      dac_b <= 16'h0;
    end
    else if (code_valid)
    begin
      dac_a <= code_a;
      dac_b <= code_b;
    end
  end
endmodule

// *** bench/scaler_sva.sv ***
// Checker for the APB answer and the sample timing of the output scaler.
// Assumes it is bound to the scaler top and sees only its ports.
`timescale 1ns/10ps
module scaler_sva #(
  parameter int SRC_W = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic signed [SRC_W-1:0] src_a,
  input wire logic signed [SRC_W-1:0] src_b,
  input wire logic sample_strobe,
  input wire logic [15:0] monitor_out_a,
  input wire logic [15:0] monitor_out_b,
  input wire logic code_valid
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s;
    psel && !penable && ce;
  endsequence
  sequence strobe_s;
    sample_strobe && ce;
  endsequence
  AST_READY_AFTER_SETUP: assert property (setup_s |=> pready)
    else $error("pready missing after setup");
  AST_READY_ONE: assert property (pready && ce |=> !pready)
    else $error("pready longer than one cycle");
  AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
    else $error("pready outside an access");
  AST_ERR_HIGH_ADDR: assert property (setup_s and
    paddr[31:18] != 14'h0 |=> pslverr && pready)
    else $error("high address not refused");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("pslverr outside a ready cycle");
  AST_VALID_AFTER: assert property (strobe_s |=> code_valid)
    else $error("code_valid missing after strobe");
  AST_VALID_CAUSE: assert property (code_valid
    |-> $past(sample_strobe))
    else $error("code_valid without strobe");
  AST_CODES_HOLD: assert property (!sample_strobe && ce
    |=> $stable(monitor_out_a) && $stable(monitor_out_b))
    else $error("codes changed without strobe");
  AST_ZERO_SRC: assert property (strobe_s and
    src_a == 0 && src_b == 0
    |=> monitor_out_a == 16'h0 && monitor_out_b == 16'h0)
    else $error("zero source gave nonzero code");
endmodule
bind analog_output_scaler scaler_sva #(.SRC_W(SRC_W)) scaler_sva_inst (
  .pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
  .prdata, .pready, .pslverr, .src_a, .src_b, .sample_strobe,
  .monitor_out_a, .monitor_out_b, .code_valid);

// *** bench/tb_top.sv ***
// Self-checking bench for the output scaler over APB and sample strobes.
// Assumes the register header indices and a 32-bit source width.
`timescale 1ns/10ps
`include "analog_output_scaler_regs.svh"
module tb_top;
  logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
  logic [31:0] paddr = 0, pwdata = 0, prdata, q;
  logic [3:0] pstrb = 4'hf;
  logic pready, pslverr, e, sample_strobe = 0, code_valid;
  logic signed [31:0] src_a = 0, src_b = 0;
  logic [15:0] monitor_out_a, monitor_out_b, dac_a, dac_b;
  int mismatches = 0, total_checks = 0;
  always #50 pclk = ~pclk;
  analog_output_scaler analog_output_scaler_inst (.pclk, .presetn, .ce,
    .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .src_a, .src_b, .sample_strobe, .monitor_out_a,
    .monitor_out_b, .code_valid);
  dac_model dac_model_inst (.pclk, .presetn, .code_valid,
    .code_a(monitor_out_a), .code_b(monitor_out_b), .dac_a, .dac_b);
  task automatic check(input string name, input logic [31:0] s, x);
    total_checks++;
    if (s !== x)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, x, s);
    end
  endtask
  task automatic apb(input logic w, input logic [15:0] idx,
                     input logic [31:0] d, input logic [13:0] hi = 14'h0);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= {hi, idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    check("wait states", n, 1);
  endtask
  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    apb(1, idx, d);
    check("write error", e, 1'b0);
  endtask
  task automatic rd(input logic [15:0] idx, input logic [31:0] x);
    apb(0, idx, 0);
    check("read error", e, 1'b0);
    check("read data", q, x);
  endtask
  task automatic smp(input logic [31:0] a, b, input logic [15:0] xa, xb);
    @(posedge pclk);
    src_a <= a;
    src_b <= b;
    sample_strobe <= 1;
    @(posedge pclk);
    sample_strobe <= 0;
    #1;
    check("code valid", code_valid, 1'b1);
    check("code a", monitor_out_a, xa);
    check("code b", monitor_out_b, xb);
    @(posedge pclk);
    #1;
    check("valid pulse", code_valid, 1'b0);
    check("dac a", dac_a, xa);
    check("dac b", dac_b, xb);
  endtask
  task automatic complete_run;
    if (mismatches == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    #2000000;
    mismatches++;
    complete_run;
  end
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1;
    rd(`ASCL_IDX_INT1, 32'h1);
    rd(`ASCL_IDX_INT2, 32'h1);
    rd(`ASCL_IDX_FIX1, 32'h00010000);
    rd(`ASCL_IDX_FIX2, 32'h00010000);
    apb(0, 16'h5f7f, 0);
    check("unmapped", e, 1'b1);
    apb(0, `ASCL_IDX_FIX1, 0, 14'h0001);
    check("high address", e, 1'b1);
    smp(32767, 32767, 16'h7fff, 16'h7fff);
    wr(`ASCL_IDX_FIX2, 32'h00008000);
    smp(32767, 32767, 16'h7fff, 16'h3fff);
    wr(`ASCL_IDX_FIX1, 32'hfff60000);
    smp(3276, -3, 16'h8008, 16'hffff);
    smp(40000, 80000, 16'h8000, 16'h7fff);
    rd(`ASCL_IDX_STATUS, 32'h7);
    wr(`ASCL_IDX_CTRL, 32'h1);
    wr(`ASCL_IDX_INT1, 32'h0000fff6);
    wr(`ASCL_IDX_INT2, 32'h0000000a);
    rd(`ASCL_IDX_INT1, 32'hfffffff6);
    smp(3276, 3276, 16'h8008, 16'h7ff8);
    smp(-4000, 4000, 16'h7fff, 16'h7fff);
    ce <= 0;
    src_a <= 32'h00000001;
    sample_strobe <= 1;
    @(posedge pclk);
    sample_strobe <= 0;
    repeat (2) @(posedge pclk);
    ce <= 1;
    #1;
    check("frozen code", monitor_out_a, 16'h7fff);
    check("frozen valid", code_valid, 1'b0);
    smp(0, 0, 16'h0000, 16'h0000);
    pstrb <= 4'h1;
    wr(`ASCL_IDX_FIX2, 32'hffffff34);
    pstrb <= 4'hf;
    rd(`ASCL_IDX_FIX2, 32'h00008034);
    apb(1, `ASCL_IDX_STATUS, 0);
    check("status write", e, 1'b1);
    @(posedge pclk);
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    rd(`ASCL_IDX_INT1, 32'h1);
    rd(`ASCL_IDX_FIX2, 32'h00010000);
    check("reset code", monitor_out_a, 16'h0);
    complete_run;
  end
endmodule

// *** logic/analog_output_scaler.sv ***
// Two-channel analog monitor scaler with an APB register slave.
// Assumes the sources and their strobe come from logic on pclk.
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/10ps
`include "analog_output_scaler_regs.svh"
// Operation
// - Two channels, each with its own factor.
// - Converter receives source times factor, not source.
// - Multiplication is signed; negative factor inverts sign.
// - Output is signed 16-bit full-scale converter code.
// - Products beyond range clamp to limits, never wrap.
// - Integer path only in older firmware variant.
// - Fixed factor: signed 32-bit, 65536 is unity.
module analog_output_scaler #(
  parameter int SRC_W = 32,
  parameter logic INT_PATH = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic signed [SRC_W-1:0] src_a,
  input wire logic signed [SRC_W-1:0] src_b,
  input wire logic sample_strobe,
  output logic [15:0] monitor_out_a,
  output logic [15:0] monitor_out_b,
  output logic code_valid
);

  // Gains come up at unity, so a fresh device passes its source through.
  localparam scaler_pkg::scaler_state_t RESET_STATE = '{
    fixed_gain: {2{`ASCL_RST_FIXED_GAIN}},
    int_gain: {2{`ASCL_RST_INT_GAIN}},
    int_mode: 1'b0,
    sat: 2'h0,
    code: {2{16'h0000}},
    code_valid: 1'b0,
    prdata: 32'h00000000,
    pready: 1'b0,
    pslverr: 1'b0
  };

  scaler_pkg::scaler_state_t st;
  scaler_pkg::scaler_state_t next_st;
  scaler_pkg::reg_sel_t sel;
  logic [1:0][SRC_W-1:0] src_vec;
  logic [1:0][15:0] ch_code;
  logic [1:0] ch_sat;
  logic setup;
  logic access;

  // Any high address bit set decodes to no register at all.
  function automatic scaler_pkg::reg_sel_t decode(input logic [31:0] addr);
    scaler_pkg::reg_sel_t s;
    s = scaler_pkg::SEL_NONE;
    if (addr[31:18] == 14'h0000)
    begin
      case (addr[17:2])
        `ASCL_IDX_CTRL: s = scaler_pkg::SEL_CTRL;
        `ASCL_IDX_STATUS: s = scaler_pkg::SEL_STATUS;
        `ASCL_IDX_CODES: s = scaler_pkg::SEL_CODES;
        `ASCL_IDX_INT1: s = INT_PATH ? scaler_pkg::SEL_INT1
                                     : scaler_pkg::SEL_NONE;
        `ASCL_IDX_INT2: s = INT_PATH ? scaler_pkg::SEL_INT2
                                     : scaler_pkg::SEL_NONE;
        `ASCL_IDX_FIX1: s = scaler_pkg::SEL_FIX1;
        `ASCL_IDX_FIX2: s = scaler_pkg::SEL_FIX2;
        default: s = scaler_pkg::SEL_NONE;
      endcase
    end
    return s;
  endfunction

  // Byte strobes keep the untouched bytes of the stored word.
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wdata,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        r[b*8 +: 8] = wdata[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // Integer gains read back sign-extended to the full bus word.
  function automatic logic [31:0] sext16(input logic [15:0] v);
    return {{16{v[15]}}, v};
  endfunction

  assign src_vec = {src_b, src_a};
  assign sel = decode(paddr);
  // A write lands only at the edge that ends its access cycle.
  assign setup = psel && !penable;
  assign access = psel && penable && st.pready;

  // Each channel has its own carrier, gains and saturation flag.
  scale_if #(.SRC_W(SRC_W)) ch [2] ();

  for (genvar i = 0; i < 2; i++)
  begin : g_chan
    assign ch[i].src = src_vec[i];
    assign ch[i].fixed_gain = st.fixed_gain[i];
    assign ch[i].int_gain = st.int_gain[i];
    assign ch[i].int_mode = st.int_mode & INT_PATH;
    assign ch_code[i] = ch[i].code;
    assign ch_sat[i] = ch[i].sat;
    channel_scaler #(.SRC_W(SRC_W)) u_scaler (
      .bus(ch[i])
    );
  end

  always_comb
  begin
    logic [31:0] rd;
    logic [31:0] wm;
    logic bad;
    rd = 32'h00000000;
    wm = 32'h00000000;
    bad = 1'b0;
    next_st = st;
    next_st.code_valid = 1'b0;

    // Both codes move together, once per strobe, with a one-cycle valid.
    if (sample_strobe)
    begin
      next_st.code = ch_code;
      next_st.sat = ch_sat;
      next_st.code_valid = 1'b1;
    end
    case (sel)
      scaler_pkg::SEL_CTRL:
        rd[`ASCL_CTRL_INT_MODE] = st.int_mode;
      scaler_pkg::SEL_STATUS:
      begin
        rd[`ASCL_STATUS_SAT_A] = st.sat[0];
        rd[`ASCL_STATUS_SAT_B] = st.sat[1];
        rd[`ASCL_STATUS_INT_PATH] = INT_PATH;
        bad = pwrite;
      end
      scaler_pkg::SEL_CODES:
      begin
        rd = {st.code[1], st.code[0]};
        bad = pwrite;
      end
      scaler_pkg::SEL_INT1: rd = sext16(st.int_gain[0]);
      scaler_pkg::SEL_INT2: rd = sext16(st.int_gain[1]);
      scaler_pkg::SEL_FIX1: rd = st.fixed_gain[0];
      scaler_pkg::SEL_FIX2: rd = st.fixed_gain[1];
      default: bad = 1'b1;
    endcase
    wm = merge(rd, pwdata, pstrb);

    // Every access answers at once; the error flag stands beside ready.
    next_st.pready = setup;
    next_st.pslverr = 1'b0;
    if (setup)
    begin
      next_st.pslverr = bad;
      if (!pwrite)
      begin
        next_st.prdata = rd;
      end
    end

    // A refused transfer changes no state.
    if (access && pwrite && !st.pslverr)
    begin
      case (sel)
        scaler_pkg::SEL_CTRL:
          if (pstrb[0])
          begin
            next_st.int_mode = pwdata[`ASCL_CTRL_INT_MODE] & INT_PATH;
          end
        scaler_pkg::SEL_INT1:
          next_st.int_gain[0] = wm[15:0];
        scaler_pkg::SEL_INT2:
          next_st.int_gain[1] = wm[15:0];
        scaler_pkg::SEL_FIX1:
          next_st.fixed_gain[0] = wm;
        scaler_pkg::SEL_FIX2:
          next_st.fixed_gain[1] = wm;
        default: next_st.int_mode = st.int_mode;
      endcase
    end
  end

  // A low clock enable freezes every register, the bus answer too.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st <= RESET_STATE;
    end
    else if (ce)
    begin
      st <= next_st;
    end
  end

  // Every output is a register bit of the state word.
  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign monitor_out_a = st.code[0];
  assign monitor_out_b = st.code[1];
  assign code_valid = st.code_valid;

endmodule

// *** logic/analog_output_scaler_regs.svh ***
// Register indices, field positions and reset values of the output scaler.
// Assumes a byte address of four times the index on a 32-bit register bus.
`ifndef ANALOG_OUTPUT_SCALER_REGS_SVH
`define ANALOG_OUTPUT_SCALER_REGS_SVH

`define ASCL_IDX_CTRL 16'h5f00
`define ASCL_IDX_STATUS 16'h5f01
`define ASCL_IDX_CODES 16'h5f02
`define ASCL_IDX_INT1 16'h5f6b
`define ASCL_IDX_INT2 16'h5f6c
`define ASCL_IDX_FIX1 16'h5fa1
`define ASCL_IDX_FIX2 16'h5fa2

`define ASCL_CTRL_INT_MODE 0
`define ASCL_STATUS_SAT_A 0
`define ASCL_STATUS_SAT_B 1
`define ASCL_STATUS_INT_PATH 2

`define ASCL_RST_FIXED_GAIN 32'h00010000
`define ASCL_RST_INT_GAIN 16'h0001
`define ASCL_FRAC_BITS 16
`define ASCL_FRAC_MASK 32'h0000ffff
`define ASCL_CODE_W 16

`endif

// *** logic/channel_scaler.sv ***
// Combinational signed scaling and saturation for one monitor channel.
// Assumes the owner registers the resulting code.
`timescale 1ns/10ps
`include "analog_output_scaler_regs.svh"
module channel_scaler #(
  parameter int SRC_W = 32
) (
  scale_if.scaler bus
);

  localparam int PW = SRC_W + 32;
  localparam int CW = `ASCL_CODE_W;

  logic signed [PW-1:0] prod_fix;
  logic signed [PW-1:0] prod_int;
  logic signed [PW-1:0] adj;
  logic signed [PW-1:0] scaled;
  logic over;

  always_comb
  begin
    prod_fix = PW'(bus.src) * PW'(bus.fixed_gain);
    prod_int = PW'(bus.src) * PW'(bus.int_gain);
    adj = prod_fix;
    if (prod_fix[PW-1])
    begin
      adj = prod_fix + $signed(PW'(`ASCL_FRAC_MASK));
    end
    scaled = bus.int_mode ? prod_int : (adj >>> `ASCL_FRAC_BITS);
    over = ~((&scaled[PW-1:CW-1]) | ~(|scaled[PW-1:CW-1]));
    if (over && !scaled[PW-1])
    begin
      bus.code = 16'h7fff;
    end
    else if (over)
    begin
      bus.code = 16'h8000;
    end
    else
    begin
      bus.code = scaled[CW-1:0];
    end
    bus.sat = over;
  end

endmodule

// *** logic/scale_if.sv ***
// Carrier between the scaler top and one channel datapath.
// Assumes the owner drives gains and source, the scaler returns the code.
`timescale 1ns/10ps
interface scale_if #(parameter int SRC_W = 32);
  logic signed [SRC_W-1:0] src;
  logic signed [31:0] fixed_gain;
  logic signed [15:0] int_gain;
  logic int_mode;
  logic [15:0] code;
  logic sat;
  modport owner (output src, fixed_gain, int_gain, int_mode,
                 input code, sat);
  modport scaler (input src, fixed_gain, int_gain, int_mode,
                  output code, sat);
endinterface

// *** logic/scaler_pkg.sv ***
// Types used by the output scaler top for its register select and state word.
// Assumes the register header supplies every number.
package scaler_pkg;

  typedef enum logic [7:0] {
    SEL_NONE = 8'h01,
    SEL_CTRL = 8'h02,
    SEL_STATUS = 8'h04,
    SEL_CODES = 8'h08,
    SEL_INT1 = 8'h10,
    SEL_INT2 = 8'h20,
    SEL_FIX1 = 8'h40,
    SEL_FIX2 = 8'h80
  } reg_sel_t;

  typedef struct packed {
    logic [1:0][31:0] fixed_gain;
    logic [1:0][15:0] int_gain;
    logic int_mode;
    logic [1:0] sat;
    logic [1:0][15:0] code;
    logic code_valid;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } scaler_state_t;

endpackage
